// ===== rtl/training_status_and_pattern_gen.sv
// Training frame serialiser: marker, control and status fields, pseudo-random pattern
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module training_status_and_pattern_gen
    import tts_pkg::*;
#(
    parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [DATA_W-1:0] reg_rdata_o,
    output logic                   tx_bit_o,
    output logic                   tx_active_o,
    output logic                   frame_start_o,
    output logic                   pattern_active_o,
    output logic                   ctrl_field_ready_o
);
    localparam int LVL_W = $clog2(FIFO_DEPTH_P) + 1;

    gen_state_t         state_r;
    gen_state_t         state_nxt;
    logic [CNT_W-1:0]   cnt_r;
    logic [CNT_W-1:0]   cnt_nxt;
    logic [CNT_W-1:0]   seg_len;
    logic               seg_last;

    logic [CTRL_W-1:0]  ctrl_r;
    logic [ACK_W-1:0]   ack_r;
    logic [FIELD_W-1:0] ctrl_word_r;
    logic [FIELD_W-1:0] status_word_r;
    logic [FIELD_W-1:0] status_live;
    logic [DATA_W-1:0]  rdata_r;
    logic [15:0]        frame_cnt_r;

    logic               tx_bit_r;
    logic               tx_bit_nxt;
    logic               active_r;
    logic               start_r;
    logic               pattern_r;

    logic               cf_push;
    logic               cf_ready;
    logic               cf_valid;
    logic               cf_pop;
    logic [FIELD_W-1:0] cf_data;
    logic [LVL_W-1:0]   cf_level;

    logic               frame_begin;
    logic               enter_ctrl;
    logic               enter_stat;
    logic [LFSR_W-1:0]  seed_state;
    logic               prbs_bit;
    logic [3:0]         bit_idx;
    logic [BIT_LEN_LOG2-1:0] sub_idx;
    logic               field_bit;

    // Register map decode and writes
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RESET;
        end else if (reg_wr_i && reg_addr_i == REG_CTRL_OFS) begin
            ctrl_r <= reg_wdata_i[CTRL_W-1:0];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ack_r <= ACK_RESET;
        end else if (reg_wr_i && reg_addr_i == REG_ACK_OFS) begin
            ack_r <= reg_wdata_i[ACK_W-1:0];
        end
    end

    assign cf_push = reg_wr_i && (reg_addr_i == REG_CFIELD_OFS);

    // Status field assembled from control and acknowledge registers
    always_comb begin
        status_live = '0;
        status_live[ST_DONE_BIT]  = ctrl_r[CTRL_DONE_BIT];
        status_live[ST_SPEED_BIT] = ctrl_r[CTRL_SPEED_BIT];
        status_live[ST_FEC_BIT]   = ctrl_r[CTRL_FEC_BIT];
        status_live[ST_FIXED_BIT] = ctrl_r[CTRL_FIXED_BIT];
        status_live[ST_RSV_LSB +: ST_RSV_W] = '0;
        status_live[ST_POST_LSB +: 2] = ack_r[ACK_POST_LSB +: 2];
        status_live[ST_MAIN_LSB +: 2] = ack_r[ACK_MAIN_LSB +: 2];
        status_live[ST_PRE_LSB +: 2]  = ack_r[ACK_PRE_LSB +: 2];
    end

    // Read data, one cycle after the strobe, zero for unmapped addresses
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_r <= '0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                REG_CTRL_OFS: begin
                    rdata_r <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};
                end
                REG_ACK_OFS: begin
                    rdata_r <= {{(DATA_W-ACK_W){1'b0}}, ack_r};
                end
                REG_CFIELD_OFS: begin
                    rdata_r <= {{(DATA_W-FIELD_W){1'b0}}, ctrl_word_r};
                end
                REG_SFIELD_OFS: begin
                    rdata_r <= {{(DATA_W-FIELD_W){1'b0}}, status_word_r};
                end
                REG_STATE_OFS: begin
                    rdata_r <= {frame_cnt_r, state_r, {(8-LVL_W){1'b0}}, cf_level};
                end
                default: begin
                    rdata_r <= '0;
                end
            endcase
        end else begin
            rdata_r <= '0;
        end
    end

    assign reg_rdata_o = rdata_r;

    // Queue of control field words, one taken per frame
    word_fifo #(
        .WIDTH (FIELD_W),
        .DEPTH (FIFO_DEPTH_P)
    ) u_cfield_fifo (
        .clk_i       (core_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (cf_push),
        .in_ready_o  (cf_ready),
        .in_data_i   (reg_wdata_i[FIELD_W-1:0]),
        .out_valid_o (cf_valid),
        .out_ready_i (cf_pop),
        .out_data_o  (cf_data),
        .level_o     (cf_level)
    );

    assign ctrl_field_ready_o = cf_ready;

    // Segment lengths per state
    always_comb begin
        case (state_r)
            ST_MARK_HI: begin
                seg_len = MARK_HALF_LEN;
            end
            ST_MARK_LO: begin
                seg_len = MARK_HALF_LEN;
            end
            ST_EXT: begin
                seg_len = EXT_LEN;
            end
            ST_CTRL: begin
                seg_len = FIELD_LEN;
            end
            ST_STAT: begin
                seg_len = FIELD_LEN;
            end
            ST_PRBS: begin
                seg_len = PRBS_LEN;
            end
            ST_ZERO: begin
                seg_len = ZERO_LEN;
            end
            default: begin
                seg_len = ZERO_LEN;
            end
        endcase
    end

    assign seg_last = (cnt_r == seg_len - 1'b1);

    // Frame sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + 1'b1;
        case (state_r)
            ST_IDLE: begin
                cnt_nxt = '0;
                if (ctrl_r[CTRL_ENABLE_BIT]) begin
                    state_nxt = ST_MARK_HI;
                end
            end
            ST_MARK_HI: begin
                if (seg_last) begin
                    state_nxt = ST_MARK_LO;
                    cnt_nxt   = '0;
                end
            end
            ST_MARK_LO: begin
                if (seg_last) begin
                    state_nxt = ctrl_r[CTRL_RATE32_BIT] ? ST_EXT : ST_CTRL;
                    cnt_nxt   = '0;
                end
            end
            ST_EXT: begin
                if (seg_last) begin
                    state_nxt = ST_CTRL;
                    cnt_nxt   = '0;
                end
            end
            ST_CTRL: begin
                if (seg_last) begin
                    state_nxt = ST_STAT;
                    cnt_nxt   = '0;
                end
            end
            ST_STAT: begin
                if (seg_last) begin
                    state_nxt = ST_PRBS;
                    cnt_nxt   = '0;
                end
            end
            ST_PRBS: begin
                if (seg_last) begin
                    state_nxt = ST_ZERO;
                    cnt_nxt   = '0;
                end
            end
            ST_ZERO: begin
                if (seg_last) begin
                    state_nxt = ctrl_r[CTRL_ENABLE_BIT] ? ST_MARK_HI : ST_IDLE;
                    cnt_nxt   = '0;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                cnt_nxt   = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign frame_begin = (state_nxt == ST_MARK_HI) && (state_r != ST_MARK_HI);
    assign enter_ctrl  = (state_nxt == ST_CTRL) && (state_r != ST_CTRL);
    assign enter_stat  = (state_nxt == ST_STAT) && (state_r != ST_STAT);
    assign cf_pop      = enter_ctrl;

    // Field words latched as each field begins, the control word only when the queue is not empty
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ctrl_word_r <= CFIELD_RESET;
        end else if (enter_ctrl && cf_valid) begin
            ctrl_word_r <= cf_data;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            status_word_r <= '0;
        end else if (enter_stat) begin
            status_word_r <= status_live;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            frame_cnt_r <= '0;
        end else if (frame_begin) begin
            frame_cnt_r <= frame_cnt_r + 1'b1;
        end
    end

    // Free-running seed source; never reaches all zeros
    lfsr_gen #(
        .WIDTH (LFSR_W),
        .TAP   (LFSR_TAP),
        .INIT  (SEED_RESET)
    ) u_seed_src (
        .clk_i     (core_clk_i),
        .rst_i     (rst_i),
        .load_i    (1'b0),
        .seed_i    ('0),
        .advance_i (1'b1),
        .state_o   (seed_state),
        .bit_o     ()
    );

    // Pattern generator reseeded each frame
    lfsr_gen #(
        .WIDTH (LFSR_W),
        .TAP   (LFSR_TAP),
        .INIT  (SEED_RESET)
    ) u_pattern (
        .clk_i     (core_clk_i),
        .rst_i     (rst_i),
        .load_i    (frame_begin),
        .seed_i    (seed_state),
        .advance_i (state_r == ST_PRBS),
        .state_o   (),
        .bit_o     (prbs_bit)
    );

    // Field bit selection, most significant first
    assign bit_idx = cnt_r[BIT_LEN_LOG2 +: 4];
    assign sub_idx = cnt_r[BIT_LEN_LOG2-1:0];
    always_comb begin
        if (state_r == ST_CTRL) begin
            field_bit = ctrl_word_r[4'(FIELD_W-1) - bit_idx];
        end else begin
            field_bit = status_word_r[4'(FIELD_W-1) - bit_idx];
        end
    end

    // Line level for the current interval
    always_comb begin
        case (state_r)
            ST_MARK_HI: begin
                tx_bit_nxt = 1'b1;
            end
            ST_MARK_LO: begin
                tx_bit_nxt = 1'b0;
            end
            ST_EXT: begin
                tx_bit_nxt = ~cnt_r[0];
            end
            ST_CTRL, ST_STAT: begin
                // Edge at every bit start, extra mid-bit edge for a one
                if (sub_idx == '0) begin
                    tx_bit_nxt = ~tx_bit_r;
                end else if (sub_idx == MID_BIT) begin
                    tx_bit_nxt = tx_bit_r ^ field_bit;
                end else begin
                    tx_bit_nxt = tx_bit_r;
                end
            end
            ST_PRBS: begin
                tx_bit_nxt = prbs_bit;
            end
            default: begin
                tx_bit_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tx_bit_r  <= 1'b0;
            active_r  <= 1'b0;
            pattern_r <= 1'b0;
            start_r   <= 1'b0;
        end else begin
            tx_bit_r  <= tx_bit_nxt;
            active_r  <= (state_r != ST_IDLE);
            pattern_r <= (state_r == ST_PRBS);
            start_r   <= frame_begin;
        end
    end

    assign tx_bit_o         = tx_bit_r;
    assign tx_active_o      = active_r;
    assign pattern_active_o = pattern_r;
    assign frame_start_o    = start_r;
endmodule : training_status_and_pattern_gen

// ===== rtl/tts_pkg.sv
// Constants, register map and state codes for the training frame generator
package tts_pkg;
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int FIELD_W = 16;
    localparam int CNT_W   = 12;
    localparam int LFSR_W  = 11;
    localparam int LFSR_TAP = 9;
    localparam int FIFO_DEPTH = 16;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] REG_CTRL_OFS   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_ACK_OFS    = 8'h04;
    localparam logic [ADDR_W-1:0] REG_CFIELD_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_SFIELD_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_STATE_OFS  = 8'h10;

    // Control register bits
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_RATE32_BIT = 1;
    localparam int CTRL_DONE_BIT   = 2;
    localparam int CTRL_SPEED_BIT  = 3;
    localparam int CTRL_FEC_BIT    = 4;
    localparam int CTRL_FIXED_BIT  = 5;
    localparam int CTRL_W          = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

    // Acknowledge register: three 2-bit codes
    localparam int ACK_W       = 6;
    localparam int ACK_POST_LSB = 4;
    localparam int ACK_MAIN_LSB = 2;
    localparam int ACK_PRE_LSB  = 0;
    localparam logic [ACK_W-1:0] ACK_RESET = 6'h00;
    localparam logic [1:0] ACK_AT_MAX = 2'h3;
    localparam logic [1:0] ACK_AT_MIN = 2'h2;
    localparam logic [1:0] ACK_DONE   = 2'h1;
    localparam logic [1:0] ACK_READY  = 2'h0;

    // Status field layout
    localparam int ST_DONE_BIT  = 15;
    localparam int ST_SPEED_BIT = 14;
    localparam int ST_FEC_BIT   = 13;
    localparam int ST_FIXED_BIT = 12;
    localparam int ST_RSV_LSB   = 6;
    localparam int ST_RSV_W     = 6;
    localparam int ST_POST_LSB  = 4;
    localparam int ST_MAIN_LSB  = 2;
    localparam int ST_PRE_LSB   = 0;

    // Segment lengths in bit intervals
    localparam logic [CNT_W-1:0] MARK_HALF_LEN = 12'd16;
    localparam logic [CNT_W-1:0] EXT_LEN       = 12'd16;
    localparam logic [CNT_W-1:0] FIELD_LEN     = 12'd128;
    localparam logic [CNT_W-1:0] PRBS_LEN      = 12'd4094;
    localparam logic [CNT_W-1:0] ZERO_LEN      = 12'd2;
    localparam int BIT_LEN_LOG2 = 3;
    localparam logic [BIT_LEN_LOG2-1:0] MID_BIT = 3'h4;

    localparam logic [LFSR_W-1:0] SEED_RESET = 11'h5A5;
    localparam logic [FIELD_W-1:0] CFIELD_RESET = 16'h0000;

    typedef enum logic [7:0] {
        ST_IDLE    = 8'h01,
        ST_MARK_HI = 8'h02,
        ST_MARK_LO = 8'h04,
        ST_EXT     = 8'h08,
        ST_CTRL    = 8'h10,
        ST_STAT    = 8'h20,
        ST_PRBS    = 8'h40,
        ST_ZERO    = 8'h80
    } gen_state_t;
endpackage : tts_pkg

// ===== rtl/lfsr_gen.sv
// Fibonacci shift register with loadable seed
`timescale 1ns/1ns
module lfsr_gen #(
    parameter int                WIDTH = 11,
    parameter int                TAP   = 9,
    parameter logic [WIDTH-1:0]  INIT  = 11'h5A5
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] seed_i,
    input  wire logic             advance_i,
    output logic      [WIDTH-1:0] state_o,
    output logic                  bit_o
);
    logic [WIDTH-1:0] state_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= INIT;
        end else if (load_i) begin
            state_r <= seed_i;
        end else if (advance_i) begin
            state_r <= {state_r[WIDTH-2:0], state_r[WIDTH-1] ^ state_r[TAP-1]};
        end
    end

    assign state_o = state_r;
    assign bit_o   = state_r[WIDTH-1];
endmodule : lfsr_gen

// ===== rtl/word_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       in_valid_i,
    output logic                            in_ready_o,
    input  wire logic [WIDTH-1:0]           in_data_i,
    output logic                            out_valid_o,
    input  wire logic                       out_ready_i,
    output logic      [WIDTH-1:0]           out_data_o,
    output logic      [$clog2(DEPTH):0]     level_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_r != DEPTH[AW:0]);
    assign out_valid_o = (count_r != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem_r[rd_ptr_r];
    assign level_o     = count_r;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : word_fifo

// ===== sim/peer_rx_model.sv
// Peer receiver model: decodes control and status fields and the pattern head
`timescale 1ns/1ns
module peer_rx_model (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        line_i,
    input  wire logic        frame_start_i,
    output logic [15:0]      ctrl_word_o,
    output logic [15:0]      status_word_o,
    output logic             word_stb_o,
    output logic [10:0]      pat_head_o
);
    logic [12:0] since_r;
    logic [12:0] fld_r;
    logic [31:0] sh_r;
    logic        ext_r;
    logic        last_r;
    assign fld_r = 13'h0020 + {8'h00, ext_r, 4'h0};
    always_ff @(posedge core_clk_i) begin
        if (rst_i) since_r <= 13'h1FFF;
        // Marker start pulse leads the line by one interval
        else if (frame_start_i) since_r <= 13'h0000;
        else if (since_r != 13'h1FFF) since_r <= since_r + 13'h0001;
    end
    always_ff @(posedge core_clk_i) begin
        last_r <= line_i;
        word_stb_o <= !rst_i && since_r == fld_r + 13'h0100;
        if (rst_i) ext_r <= 1'b0;
        else if (since_r == 13'h0021) ext_r <= !line_i;
        // Mid-bit transition means a one
        if (since_r >= fld_r && since_r < fld_r + 13'h0100 && since_r[2:0] == 3'h4)
            sh_r <= {sh_r[30:0], line_i != last_r};
        if (since_r == fld_r + 13'h0100) begin
            ctrl_word_o <= sh_r[31:16];
            status_word_o <= sh_r[15:0];
        end
        if (since_r >= fld_r + 13'h0100 && since_r < fld_r + 13'h010B)
            pat_head_o <= {pat_head_o[9:0], line_i};
    end
endmodule : peer_rx_model

// ===== sim/training_status_and_pattern_gen_chk.sv
// Concurrent checks on the training frame generator ports
`timescale 1ns/1ns
module training_status_and_pattern_gen_chk
    import tts_pkg::*;
#(
    parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
    input wire logic              core_clk_i,
    input wire logic              rst_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic              reg_rd_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic              tx_bit_o,
    input wire logic              tx_active_o,
    input wire logic              frame_start_o,
    input wire logic              pattern_active_o
);
    logic [12:0] since_r;
    logic [12:0] run_r;
    logic        ext_r;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge core_clk_i) begin
        if (rst_i) since_r <= 13'h1FFF;
        // Marker start pulse leads the line by one interval
        else if (frame_start_o) since_r <= 13'h0000;
        else if (since_r != 13'h1FFF) since_r <= since_r + 13'h0001;
    end
    always_ff @(posedge core_clk_i) begin
        if (rst_i) run_r <= 13'h0000;
        else run_r <= pattern_active_o ? run_r + 13'h0001 : 13'h0000;
    end
    // Low line in the second cycle after the marker halves means extended marker
    always_ff @(posedge core_clk_i) begin
        if (rst_i) ext_r <= 1'b0;
        else if (since_r == 13'h0021) ext_r <= !tx_bit_o;
    end
    a_marker_shape: assert property (frame_start_o |=> tx_bit_o [*8] ##1 tx_bit_o [*8] ##1
        !tx_bit_o [*8] ##1 !tx_bit_o [*8]) else $error("frame marker shape wrong");
    a_pattern_recur: assert property (pattern_active_o && $past(pattern_active_o, 11)
        |-> tx_bit_o == ($past(tx_bit_o, 11) ^ $past(tx_bit_o, 9))) else $error("pattern recurrence broken");
    a_pattern_len: assert property ($fell(pattern_active_o) |-> run_r == 13'h0FFE)
        else $error("pattern run length wrong");
    a_zero_tail: assert property ($fell(pattern_active_o) |-> !tx_bit_o ##1 !tx_bit_o)
        else $error("zero tail missing");
    a_fields_len: assert property ($rose(pattern_active_o) |-> since_r == 13'h0120 + {ext_r, 4'h0})
        else $error("field span wrong");
    a_bit_edge: assert property (since_r >= 13'h0030 && since_r < 13'h0120 + {ext_r, 4'h0}
        && since_r[2:0] == 3'h0 |-> tx_bit_o != $past(tx_bit_o)) else $error("no edge at bit start");
    a_ext_toggle: assert property (ext_r && since_r > 13'h0021 && since_r < 13'h0030
        |-> tx_bit_o != $past(tx_bit_o)) else $error("extended marker not alternating");
    a_next_frame: assert property ($fell(pattern_active_o) ##2 tx_active_o |-> $past(frame_start_o) && tx_bit_o)
        else $error("next marker not after two zeros");
    a_status_rsv: assert property ($past(reg_rd_i) && $past(reg_addr_i) == REG_SFIELD_OFS
        |-> reg_rdata_o[11:6] == 6'h00) else $error("reserved status bits set");
    c_frame: cover property (frame_start_o);
    c_ext: cover property ($rose(pattern_active_o) && ext_r);
    c_tail: cover property ($fell(pattern_active_o));
endmodule : training_status_and_pattern_gen_chk
bind training_status_and_pattern_gen training_status_and_pattern_gen_chk #(.FIFO_DEPTH_P(FIFO_DEPTH_P)) i_chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .tx_bit_o(tx_bit_o), .tx_active_o(tx_active_o),
    .frame_start_o(frame_start_o), .pattern_active_o(pattern_active_o));

// ===== sim/training_status_and_pattern_gen_tb_top.sv
// Testbench: register-driven frames decoded by the peer model
`timescale 1ns/1ns
module training_status_and_pattern_gen_tb_top;
    import tts_pkg::*;
    typedef struct packed {logic [5:0] ctrl; logic [5:0] ack; logic [15:0] cword; logic [15:0] status;} row_t;
    logic              core_clk_i, rst_i, reg_wr_i, reg_rd_i, word_stb;
    logic [ADDR_W-1:0] reg_addr_i;
    logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, rd_val;
    logic              tx_bit_o, tx_active_o, frame_start_o, pattern_active_o, ctrl_field_ready_o;
    logic [15:0]       peer_ctrl, peer_status;
    logic [10:0]       peer_pat, prev_pat;
    int                miscompares, samples_checked, n;
    row_t rows[5] = '{'{6'h05, 6'h39, 16'hA5C3, 16'h8039}, '{6'h0B, 6'h27, 16'h0001, 16'h4027},
                      '{6'h11, 6'h1E, 16'h8000, 16'h201E}, '{6'h21, 6'h00, 16'hFFFF, 16'h1000},
                      '{6'h3F, 6'h3F, 16'h3C5A, 16'hF03F}};
    training_status_and_pattern_gen i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .tx_bit_o(tx_bit_o), .tx_active_o(tx_active_o), .frame_start_o(frame_start_o),
        .pattern_active_o(pattern_active_o), .ctrl_field_ready_o(ctrl_field_ready_o));
    peer_rx_model i_peer (.core_clk_i(core_clk_i), .rst_i(rst_i), .line_i(tx_bit_o), .frame_start_i(frame_start_o),
        .ctrl_word_o(peer_ctrl), .status_word_o(peer_status), .word_stb_o(word_stb), .pat_head_o(peer_pat));
    task complete_run;
        $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge core_clk_i);
    endtask : wr
    task rd(input logic [7:0] a);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 rd_val = reg_rdata_o;
        @(posedge core_clk_i);
    endtask : rd
    // Bounded wait on a peer word, or on the line going idle
    task wait_for(input logic idle);
        int i;
        i = 0;
        do begin
            @(posedge core_clk_i);
            #1 i++;
        end while ((idle ? tx_active_o !== 1'b0 : word_stb !== 1'b1) && i < 5000);
        if (i >= 5000) begin
            miscompares++;
            complete_run;
        end else begin
            @(posedge core_clk_i);
        end
    endtask : wait_for
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    initial begin
        miscompares = 0;
        samples_checked = 0;
        rst_i <= 1'b1;
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        reg_addr_i <= 8'h00;
        reg_wdata_i <= 32'h0;
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        rd(REG_STATE_OFS);
        chk(rd_val, 32'h0000_0100);
        rd(8'h20);
        chk(rd_val, 32'h0);
        for (int r = 0; r < 5; r++) begin
            wr(REG_CFIELD_OFS, {16'h0, rows[r].cword});
            wr(REG_ACK_OFS, {26'h0, rows[r].ack});
            wr(REG_CTRL_OFS, {26'h0, rows[r].ctrl});
            wait_for(1'b0);
            // Let the whole pattern head of this frame arrive
            repeat (12) @(posedge core_clk_i);
            prev_pat = peer_pat;
            wait_for(1'b0);
            repeat (12) @(posedge core_clk_i);
            chk({16'h0, peer_status}, {16'h0, rows[r].status});
            chk({16'h0, peer_ctrl}, {16'h0, rows[r].cword});
            chk({31'h0, peer_pat != 11'h000}, 32'h1);
            chk({31'h0, peer_pat != prev_pat}, 32'h1);
            rd(REG_SFIELD_OFS);
            chk(rd_val, {16'h0, rows[r].status});
        end
        wr(REG_CTRL_OFS, 32'h0);
        wait_for(1'b1);
        n = 0;
        while (ctrl_field_ready_o === 1'b1 && n < 20) begin
            wr(REG_CFIELD_OFS, n);
            n++;
        end
        chk(n, FIFO_DEPTH);
        wr(REG_CFIELD_OFS, 32'hFFFF);
        rd(REG_STATE_OFS);
        chk(rd_val[15:0], 16'h0110);
        rst_i <= 1'b1;
        @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        rd(REG_STATE_OFS);
        chk(rd_val[15:0], 16'h0100);
        complete_run;
    end
endmodule : training_status_and_pattern_gen_tb_top
